// ===== sbp_sram_port.sv
// Purpose: synchronous pipelined burst sram port, wide variant
// Assumes: bus master runs on clk_in; mode and sleep are async pins
// Notes:   first word three clocks after the address, then one per clock
//
// Behaviour
// - register every synchronous input each rising edge
// - load address and selects only on strobe
// - later burst addresses made internally on step
// - two-bit counter seeded from loaded address
// - interleaved or linear order by configuration
// - registered writes complete self-timed, no extra strobes
// - byte-lane writes; unselected lanes keep contents
// - global write low writes every lane
// - output enable and sleep act asynchronously
// - registered inputs and outputs form pipeline
// - burst timing three-one-one-one clocks
// - inactive selects release outputs three clocks after the address
// - array is 524288 words of 36 bits
`include "sbp_consts.svh"
`default_nettype none
module sbp_sram_port
   import sbp_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire sbp_addr_t  addr_in,
   input  wire logic       processor_addr_strobe_n_in,
   input  wire logic       controller_addr_strobe_n_in,
   input  wire logic       burst_step_n_in,
   input  wire logic       pipelined_chip_select_n_in,
   input  wire logic       depth_select_high_in,
   input  wire logic       depth_select_low_n_in,
   input  wire logic       global_write_n_in,
   input  wire logic       byte_write_enable_n_in,
   input  wire sbp_lanes_t byte_lane_write_n_in,
   input  wire logic       out_enable_n_in,
   input  wire logic       sleep_request_in,
   input  wire logic       linear_burst_in,
   input  wire sbp_word_t  dq_in,
   output sbp_word_t       dq_out,
   output logic            dq_oe_out
);
   typedef struct packed {
      logic [1:0] sleep_sync;
      logic [1:0] linear_sync;
      sbp_pins_t  pins;
      sbp_mode_t  mode;
      logic [`SBP_ADDR_W-`SBP_CNT_W-1:0] group;
      logic       desel_seen;
      logic       wr_seen;
      sbp_word_t  dq;
      logic       drive;
   } sbp_port_state_t;

   sbp_port_state_t st_reg;
   sbp_port_state_t st_next;
   logic            rst_n_int;
   logic [1:0]      rst_sync_reg;
   sbp_pins_t       p;
   logic            selected;
   logic            proc_load;
   logic            load;
   logic            step;
   logic            is_write;
   logic            do_write;
   logic            do_read;
   sbp_lanes_t      lane_we;
   logic [`SBP_CNT_W-1:0] low_addr;
   sbp_addr_t       cur_addr;
   sbp_addr_t       acc_addr;
   sbp_word_t       rd_word;
   logic            buf_in_ready;
   logic            buf_out_valid;
   sbp_word_t       buf_out_data;
   logic            drain;

   assign rst_n_int = rst_sync_reg[1];
   assign p         = st_reg.pins;
   assign selected  = !p.pipelined_chip_select_n && p.depth_select_high
                      && !p.depth_select_low_n;
   // processor strobe is ignored while the pipelined select is high
   assign proc_load = !p.processor_addr_strobe_n && !p.pipelined_chip_select_n;
   assign load      = (proc_load || !p.controller_addr_strobe_n)
                      && !st_reg.sleep_sync[1];
   assign step      = !load && st_reg.mode == SBP_ACTIVE && !p.burst_step_n
                      && buf_in_ready;
   // a processor-strobe start is always a read; writes follow it
   assign is_write  = !p.global_write_n
                      || (!p.byte_write_enable_n && !(&p.byte_lane_write_n));
   assign cur_addr  = {st_reg.group, low_addr};
   assign acc_addr  = load ? p.addr : cur_addr;
   assign do_write  = is_write && !proc_load
                      && ((load && selected) || (!load && st_reg.mode == SBP_ACTIVE));
   assign do_read   = !is_write || proc_load ? ((load && selected) || step) : 1'b0;
   assign drain     = !st_reg.sleep_sync[1];

   always_comb begin
      lane_we = '0;
      if (!p.global_write_n) begin
         lane_we = '1;
      end else if (!p.byte_write_enable_n) begin
         lane_we = ~p.byte_lane_write_n;
      end
   end

   sbp_burst_ctr u_ctr (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_int),
      .load_in      (load && selected),
      .seed_in      (p.addr[`SBP_CNT_W-1:0]),
      .step_in      (step),
      .linear_in    (st_reg.linear_sync[1]),
      .low_addr_out (low_addr)
   );

   // one array per byte lane, so a lane write leaves the others alone
   genvar gl;
   generate
      for (gl = 0; gl < `SBP_LANES; gl++) begin : g_lane
         logic [`SBP_LANE_W-1:0] mem [0:`SBP_DEPTH-1];
         always_ff @(posedge clk_in) begin
            if (do_write && lane_we[gl]) begin
               mem[acc_addr] <= p.data[gl*`SBP_LANE_W +: `SBP_LANE_W];
            end
         end
         assign rd_word[gl*`SBP_LANE_W +: `SBP_LANE_W] = mem[acc_addr];
      end
   endgenerate

   sbp_skid_buf u_buf (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_int),
      .in_valid_in   (do_read),
      .in_data_in    (rd_word),
      .in_ready_out  (buf_in_ready),
      .out_valid_out (buf_out_valid),
      .out_data_out  (buf_out_data),
      .out_ready_in  (drain)
   );

   always_comb begin
      st_next             = st_reg;
      st_next.sleep_sync  = {st_reg.sleep_sync[0], sleep_request_in};
      st_next.linear_sync = {st_reg.linear_sync[0], linear_burst_in};
      st_next.pins        = '{addr_in, processor_addr_strobe_n_in,
                              controller_addr_strobe_n_in, burst_step_n_in,
                              pipelined_chip_select_n_in, depth_select_high_in,
                              depth_select_low_n_in, global_write_n_in,
                              byte_write_enable_n_in, byte_lane_write_n_in,
                              dq_in};
      st_next.desel_seen  = load && !selected;
      st_next.wr_seen     = do_write;
      if (load) begin
         st_next.mode  = selected ? SBP_ACTIVE : SBP_IDLE;
         st_next.group = p.addr[`SBP_ADDR_W-1:`SBP_CNT_W];
      end
      // output register: third edge after the address pins
      if (buf_out_valid && drain) begin
         st_next.dq    = buf_out_data;
         st_next.drive = 1'b1;
      end else if (st_reg.desel_seen || st_reg.wr_seen) begin
         st_next.drive = 1'b0;
      end
   end

   // reset synchroniser sits apart: it alone is cleared by the raw pin
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_reg.sleep_sync  <= 2'h0;
         st_reg.linear_sync <= 2'h0;
         st_reg.pins        <= '1;
         st_reg.mode        <= SBP_IDLE;
         st_reg.group       <= '0;
         st_reg.desel_seen  <= 1'b0;
         st_reg.wr_seen     <= 1'b0;
         st_reg.dq          <= '0;
         st_reg.drive       <= 1'b0;
      end else begin
         st_reg.sleep_sync  <= st_next.sleep_sync;
         st_reg.linear_sync <= st_next.linear_sync;
         st_reg.pins        <= st_next.pins;
         st_reg.mode        <= st_next.mode;
         st_reg.group       <= st_next.group;
         st_reg.desel_seen  <= st_next.desel_seen;
         st_reg.wr_seen     <= st_next.wr_seen;
         st_reg.dq          <= st_next.dq;
         st_reg.drive       <= st_next.drive;
      end
   end

   assign dq_out    = st_reg.dq;
   // enable and sleep gate the drive without waiting for a clock edge
   assign dq_oe_out = st_reg.drive && !out_enable_n_in && !sleep_request_in;
endmodule : sbp_sram_port
`default_nettype wire

// ===== sbp_consts.svh
// Purpose: constants of the pipelined burst sram port
// Assumes: wide variant, 512k words of 36 bits
// Notes:   definitions only
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH
`define SBP_ADDR_W   19
`define SBP_DEPTH    524288
`define SBP_DATA_W   36
`define SBP_LANES    4
`define SBP_LANE_W   9
`define SBP_BUF_N    2
`define SBP_CNT_W    2
`define SBP_RST_CNT  2'h0
`endif

// ===== sbp_pkg.sv
// Purpose: shared types of the pipelined burst sram port
// Assumes: sbp_consts.svh gives the widths
// Notes:   pins travel as one registered struct
`include "sbp_consts.svh"
`default_nettype none
package sbp_pkg;
   typedef logic [`SBP_ADDR_W-1:0] sbp_addr_t;
   typedef logic [`SBP_DATA_W-1:0] sbp_word_t;
   typedef logic [`SBP_LANES-1:0]  sbp_lanes_t;

   typedef struct packed {
      sbp_addr_t  addr;
      logic       processor_addr_strobe_n;
      logic       controller_addr_strobe_n;
      logic       burst_step_n;
      logic       pipelined_chip_select_n;
      logic       depth_select_high;
      logic       depth_select_low_n;
      logic       global_write_n;
      logic       byte_write_enable_n;
      sbp_lanes_t byte_lane_write_n;
      sbp_word_t  data;
   } sbp_pins_t;

   typedef enum logic [0:0] {
      SBP_IDLE   = 1'b0,
      SBP_ACTIVE = 1'b1
   } sbp_mode_t;
endpackage : sbp_pkg
`default_nettype wire

// ===== sbp_burst_ctr.sv
// Purpose: two-bit burst address counter
// Assumes: load and step never both act; load wins
// Notes:   only the two low address bits ever change; output shows the next count
`include "sbp_consts.svh"
`default_nettype none
module sbp_burst_ctr
   import sbp_pkg::*;
(
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  load_in,
   input  wire logic [`SBP_CNT_W-1:0] seed_in,
   input  wire logic                  step_in,
   input  wire logic                  linear_in,
   output logic      [`SBP_CNT_W-1:0] low_addr_out
);
   typedef struct packed {
      logic [`SBP_CNT_W-1:0] seed;
      logic [`SBP_CNT_W-1:0] count;
   } sbp_ctr_state_t;

   sbp_ctr_state_t st_reg;
   sbp_ctr_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (load_in) begin
         st_next.seed  = seed_in;
         st_next.count = `SBP_RST_CNT;
      end else if (step_in) begin
         st_next.count = st_reg.count + 2'h1;              // wraps in group
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // linear adds, interleaved xors the seed
   // next count, so a stepped cycle reads the new word, not the old one again
   assign low_addr_out = linear_in ? st_next.seed + st_next.count
                                   : st_next.seed ^ st_next.count;
endmodule : sbp_burst_ctr
`default_nettype wire

// ===== sbp_skid_buf.sv
// Purpose: two-entry buffer on the read data path
// Assumes: one clock
// Notes:   honest full and empty; a stalled drain fills it
`include "sbp_consts.svh"
`default_nettype none
module sbp_skid_buf
   import sbp_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      rst_n_in,
   input  wire logic      in_valid_in,
   input  wire sbp_word_t in_data_in,
   output logic           in_ready_out,
   output logic           out_valid_out,
   output sbp_word_t      out_data_out,
   input  wire logic      out_ready_in
);
   typedef struct packed {
      sbp_word_t [`SBP_BUF_N-1:0] entry;
      logic                       wr_ptr;
      logic                       rd_ptr;
      logic [1:0]                 fill;
   } sbp_buf_state_t;

   sbp_buf_state_t st_reg;
   sbp_buf_state_t st_next;
   logic           push;
   logic           pop;

   assign in_ready_out  = st_reg.fill != 2'h2;
   assign out_valid_out = st_reg.fill != 2'h0;
   assign out_data_out  = st_reg.entry[st_reg.rd_ptr];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.entry[st_reg.wr_ptr] = in_data_in;
         st_next.wr_ptr               = ~st_reg.wr_ptr;
      end
      if (pop) begin
         st_next.rd_ptr = ~st_reg.rd_ptr;
      end
      if (push && !pop) begin
         st_next.fill = st_reg.fill + 2'h1;
      end else if (pop && !push) begin
         st_next.fill = st_reg.fill - 2'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : sbp_skid_buf
`default_nettype wire

// ===== sbp_port_props.sv
// Purpose: pin timing checks for the sram port
// Assumes: one clock; the async pins only ever force the drive off
// Notes:   antecedents keep the bus quiet so later starts cannot blur them
`default_nettype none
module sbp_port_props
   import sbp_pkg::*;
(
   input wire logic      clk_in,
   input wire logic      rst_n_in,
   input wire logic      processor_addr_strobe_n_in,
   input wire logic      controller_addr_strobe_n_in,
   input wire logic      burst_step_n_in,
   input wire logic      pipelined_chip_select_n_in,
   input wire logic      depth_select_high_in,
   input wire logic      depth_select_low_n_in,
   input wire logic      global_write_n_in,
   input wire logic      byte_write_enable_n_in,
   input wire logic      out_enable_n_in,
   input wire logic      sleep_request_in,
   input wire sbp_word_t dq_out,
   input wire logic      dq_oe_out
);
   logic sel_ok, no_wr, quiet, drv_ok;
   assign sel_ok = !pipelined_chip_select_n_in && depth_select_high_in && !depth_select_low_n_in;
   assign no_wr = global_write_n_in && byte_write_enable_n_in;
   assign quiet = processor_addr_strobe_n_in && controller_addr_strobe_n_in && no_wr
      && !sleep_request_in;
   // async pins may blank the drive at any moment
   assign drv_ok = dq_oe_out || out_enable_n_in || sleep_request_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_start;
      (!processor_addr_strobe_n_in || !controller_addr_strobe_n_in) && sel_ok && no_wr
         && !sleep_request_in;
   endsequence
   sequence s_desel;
      !controller_addr_strobe_n_in && !sel_ok ##1 quiet[*2];
   endsequence
   sequence s_write;
      !controller_addr_strobe_n_in && sel_ok && !global_write_n_in ##1 quiet[*2];
   endsequence
   property p_first_word; s_start ##1 quiet[*2] |-> ##1 drv_ok; endproperty
   property p_burst; s_start ##1 (quiet && !burst_step_n_in)[*3] |-> ##1 drv_ok[*4]; endproperty
   property p_desel; s_desel |-> ##1 !dq_oe_out; endproperty
   property p_write_release; s_write |-> ##1 !dq_oe_out; endproperty
   property p_no_start; quiet[*3] ##1 (quiet && !out_enable_n_in && !dq_oe_out)
      |-> ##1 !dq_oe_out; endproperty
   property p_oe_pin; out_enable_n_in |-> !dq_oe_out; endproperty
   property p_sleep_pin; sleep_request_in |-> !dq_oe_out; endproperty
   property p_reset_out; $rose(rst_n_in) |-> (!dq_oe_out && dq_out == '0)[*2]; endproperty
   a_first_word: assert property (p_first_word) else $error("read not driven on third clock");
   a_burst: assert property (p_burst) else $error("burst drive broke");
   a_desel: assert property (p_desel) else $error("deselect did not release");
   a_write_release: assert property (p_write_release) else $error("write kept drive");
   a_no_start: assert property (p_no_start) else $error("drive without a strobe");
   a_oe_pin: assert property (p_oe_pin) else $error("drive with enable off");
   a_sleep_pin: assert property (p_sleep_pin) else $error("drive while asleep");
   a_reset_out: assert property (p_reset_out) else $error("outputs live after reset");
endmodule : sbp_port_props
bind sbp_sram_port sbp_port_props u_props (.clk_in, .rst_n_in, .processor_addr_strobe_n_in,
   .controller_addr_strobe_n_in, .burst_step_n_in, .pipelined_chip_select_n_in,
   .depth_select_high_in, .depth_select_low_n_in, .global_write_n_in, .byte_write_enable_n_in,
   .out_enable_n_in, .sleep_request_in, .dq_out, .dq_oe_out);
`default_nettype wire

// ===== sbp_bus_master.sv
// Purpose: bus master model driving the sram port pins
// Assumes: drives 1 ns after each rising edge
// Notes:   address and data wander between starts, so stale values never help
`default_nettype none
module sbp_bus_master
   import sbp_pkg::*;
(
   input  wire logic clk_in,
   output sbp_pins_t pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pins_out = '1;
      pins_out.pipelined_chip_select_n = 1'b0;
      pins_out.depth_select_low_n = 1'b0;
   end
   task automatic cyc(input logic step_n);
      @(posedge clk_in);
      #1;
      pins_out.addr = ~pins_out.addr;
      pins_out.data = ~pins_out.data;
      pins_out.processor_addr_strobe_n = 1'b1;
      pins_out.controller_addr_strobe_n = 1'b1;
      pins_out.pipelined_chip_select_n = 1'b0;
      pins_out.depth_select_high = 1'b1;
      pins_out.depth_select_low_n = 1'b0;
      pins_out.burst_step_n = step_n;
      {pins_out.global_write_n, pins_out.byte_write_enable_n, pins_out.byte_lane_write_n} = 6'h3f;
   endtask : cyc
   // desel 1 to 3 drops one of the three chip selects for this start only
   task automatic op(input sbp_addr_t a, input logic proc, input logic [5:0] w,
                     input sbp_word_t d, input logic [1:0] desel);
      @(posedge clk_in);
      #1;
      pins_out.addr = a;
      pins_out.data = d;
      pins_out.processor_addr_strobe_n = !proc;
      pins_out.controller_addr_strobe_n = proc;
      pins_out.pipelined_chip_select_n = desel == 2'h1;
      pins_out.depth_select_high = desel != 2'h2;
      pins_out.depth_select_low_n = desel == 2'h3;
      pins_out.burst_step_n = 1'b1;
      {pins_out.global_write_n, pins_out.byte_write_enable_n, pins_out.byte_lane_write_n} = w;
   endtask : op
endmodule : sbp_bus_master
`default_nettype wire

// ===== test_pipelined_burst_sram_port.sv
// Purpose: self-checking bench for the pipelined burst sram port
// Assumes: the master model drives the bus, async pins are driven here
// Notes:   expected memory lives here; only written words are ever read
`include "sbp_consts.svh"
`default_nettype none
`define SBP_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_pipelined_burst_sram_port
   import sbp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic      clk_in, rst_n_in, out_enable_n_in, sleep_request_in, linear_burst_in, dq_oe_out;
   sbp_pins_t p;
   sbp_word_t dq_out;
   int        err_total, checked;
   sbp_word_t mem [sbp_addr_t];
   sbp_bus_master master (.clk_in(clk_in), .pins_out(p));
   sbp_sram_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(p.addr),
      .processor_addr_strobe_n_in(p.processor_addr_strobe_n),
      .controller_addr_strobe_n_in(p.controller_addr_strobe_n),
      .burst_step_n_in(p.burst_step_n), .pipelined_chip_select_n_in(p.pipelined_chip_select_n),
      .depth_select_high_in(p.depth_select_high), .depth_select_low_n_in(p.depth_select_low_n),
      .global_write_n_in(p.global_write_n), .byte_write_enable_n_in(p.byte_write_enable_n),
      .byte_lane_write_n_in(p.byte_lane_write_n), .out_enable_n_in(out_enable_n_in),
      .sleep_request_in(sleep_request_in), .linear_burst_in(linear_burst_in), .dq_in(p.data),
      .dq_out(dq_out), .dq_oe_out(dq_oe_out));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic wr(input sbp_addr_t a, input logic [5:0] w, input sbp_word_t d);
      sbp_word_t m;
      m = mem[a];
      for (int k = 0; k < `SBP_LANES; k++) begin
         if (!w[5] || (!w[4] && !w[k])) begin
            m[k*`SBP_LANE_W +: `SBP_LANE_W] = d[k*`SBP_LANE_W +: `SBP_LANE_W];
         end
      end
      mem[a] = m;
      master.op(a, 1'b0, w, d, 2'h0);
      master.cyc(1'b1);
      master.cyc(1'b1);
   endtask : wr
   // n words from a; the address pins wander while the port counts
   task automatic rd(input sbp_addr_t a, input logic proc, input int n);
      sbp_addr_t e;
      master.op(a, proc, 6'h3f, 36'h5_a5a5_a5a5, 2'h0);
      for (int i = 1; i <= n + 2; i++) begin
         master.cyc(i >= n);
         if (i >= 3) begin
            e = a;
            e[1:0] = linear_burst_in ? a[1:0] + 2'(i - 3) : a[1:0] ^ 2'(i - 3);
            `SBP_CHK("read word", mem[e], dq_out)
            `SBP_CHK("read drive", 1'b1, dq_oe_out)
         end
      end
   endtask : rd
   task automatic t_bursts();
      for (int k = 0; k < 4; k++) begin
         wr(19'h7fffc + 19'(k), k[0] ? 6'h1f : 6'h00, {9'(k + 1), 9'(k + 2), 9'(k), 9'h1c3});
      end
      for (int m = 0; m < 4; m++) begin
         linear_burst_in = m[1];
         repeat (4) master.cyc(1'b1);
         rd(19'h7fffc | 19'(m[0] ? 3 : 1), 1'b0, 4);
      end
   endtask : t_bursts
   task automatic t_lanes();
      logic [3:0] lanes [4] = '{4'he, 4'hc, 4'h0, 4'h5};
      wr(19'h00123, 6'h1f, 36'h1_2345_6789);
      for (int k = 0; k < 4; k++) begin
         wr(19'h00123, {2'b10, lanes[k]}, 36'hf_edcb_a987 ^ 36'(k));
         rd(19'h00123, 1'b0, 1);
      end
   endtask : t_lanes
   // each pass drops a different one of the three chip selects
   task automatic t_desel();
      for (int k = 1; k < 4; k++) begin
         rd(19'h7fffd, k == 1, 4 - k);
         master.op(19'h7fffd, 1'b0, 6'h3f, 36'h0_0000_0000, 2'(k));
         master.cyc(1'b1);
         master.cyc(1'b1);
         `SBP_CHK("drive before deselect", 1'b1, dq_oe_out)
         master.cyc(1'b1);
         `SBP_CHK("drive after deselect", 1'b0, dq_oe_out)
      end
   endtask : t_desel
   // each pin is checked mid-cycle, before any edge could have carried it
   task automatic t_async();
      rd(19'h7fffe, 1'b0, 1);
      out_enable_n_in = 1'b1;
      #1;
      `SBP_CHK("enable off", 1'b0, dq_oe_out)
      master.cyc(1'b1);
      out_enable_n_in = 1'b0;
      #1;
      `SBP_CHK("enable on", 1'b1, dq_oe_out)
      master.cyc(1'b1);
      sleep_request_in = 1'b1;
      #1;
      `SBP_CHK("sleep off", 1'b0, dq_oe_out)
      master.cyc(1'b1);
      master.cyc(1'b1);
      // start while asleep must be ignored; old word stays on the output
      master.op(19'h7fffc, 1'b0, 6'h3f, 36'h0_0000_0000, 2'h0);
      master.cyc(1'b1);
      sleep_request_in = 1'b0;
      repeat (4) master.cyc(1'b1);
      `SBP_CHK("no start in sleep", mem[19'h7fffe], dq_out)
      `SBP_CHK("drive after sleep", 1'b1, dq_oe_out)
      repeat (4) master.cyc(1'b1);
   endtask : t_async
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      #(20 * 3000);
      err_total++;
      final_report();
   end
   initial begin
      {rst_n_in, out_enable_n_in, sleep_request_in, linear_burst_in} = 4'h0;
      err_total = 0;
      checked = 0;
      repeat (20) @(posedge clk_in);
      #1;
      `SBP_CHK("reset data", 36'h0_0000_0000, dq_out)
      `SBP_CHK("reset drive", 1'b0, dq_oe_out)
      rst_n_in = 1'b1;
      repeat (3) master.cyc(1'b1);
      t_bursts();
      t_lanes();
      t_desel();
      t_async();
      final_report();
   end
endmodule : test_pipelined_burst_sram_port
`default_nettype wire
